// [src/udrh_pkg.sv]
// Package: constants for USB device reset handling block.
// Assumes a 50 MHz clock and line state sampled synchronously.
package udrh_pkg;
    localparam int unsigned CLOCK_HZ          = 50000000;
    // Bus reset must persist this long before it counts (ns)
    localparam int unsigned RESET_DETECT_NS   = 2500;
    localparam int unsigned RESET_DETECT_CYC  =
        (RESET_DETECT_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
    // Spacing of repeated reset interrupt pulses during one bus reset (ns)
    localparam int unsigned RESET_REPEAT_NS   = 1000;
    localparam int unsigned RESET_REPEAT_CYC  =
        (RESET_REPEAT_NS * (CLOCK_HZ / 1000000)) / 1000;
    // Length of internal soft reset pulse (ns)
    localparam int unsigned SOFT_RESET_NS     = 400;
    localparam int unsigned SOFT_RESET_CYC    =
        (SOFT_RESET_NS * (CLOCK_HZ / 1000000) + 19) / 1000 + 1;
    localparam int unsigned COUNT_W           = 8;

    typedef enum logic [1:0] {
        UDRH_IDLE    = 2'b00,
        UDRH_QUALIFY = 2'b01,
        UDRH_ACTIVE  = 2'b10
    } udrh_state_t;
endpackage : udrh_pkg

// [src/udrh_soft_reset.sv]
// Soft reset sequencer: holds an internal reset for a fixed count.
// Assumes request is a one-cycle write strobe of the control bit.
`timescale 1ns/1ns
module udrh_soft_reset (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic request,
    output logic      busy
);
    logic [udrh_pkg::COUNT_W-1:0] count;
    wire                          lastCycle = (count == udrh_pkg::COUNT_W'(1));

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
            busy  <= 1'b0;
        end else if (request && !busy) begin
            count <= udrh_pkg::COUNT_W'(udrh_pkg::SOFT_RESET_CYC);
            busy  <= 1'b1;
        end else if (busy) begin
            count <= count - udrh_pkg::COUNT_W'(1);
            busy  <= !lastCycle;
        end
    end
endmodule : udrh_soft_reset

// [src/udrh_top.sv]
// Device-side bus reset detection and soft reset control.
// Assumes dp/dm line levels synchronous to clock; no register bus.
// Functional notes
// - After attach, both data lines low is a bus reset; interrupt may repeat.
// - Reset interrupt pulses only while bus reset signaling lasts.
// - Bus-reset status bit clears itself when host removes reset signaling.
// - Writing one to soft reset bit starts reset; bit self-clears when done.
// - System and power-on resets meet internal timing with no extra sequencing.
`timescale 1ns/1ns
module udrh_top (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic deviceMode,
    input  wire logic attached,
    input  wire logic linePlus,
    input  wire logic lineMinus,
    input  wire logic softResetWrite,
    output logic      resetIrq,
    output logic      busResetStatus,
    output logic      softResetRequestBit,
    output logic      coreReset_n
);
    // Bus reset timeline at 50 MHz:
    //   line low first seen -> qualify span of RESET_DETECT_CYC cycles
    //   qualify span ends   -> first interrupt pulse, status bit set
    //   each RESET_REPEAT_CYC cycles while still low -> another pulse
    //   line released       -> status bit drops on the next edge
    // Repeated pulses are deliberate; software takes each one and
    // waits for the status bit to fall before its own setup.

    // Both data lines low on the pair: single-ended zero
    function automatic logic lineIsLow(
        input logic plus,
        input logic minus
    );
        lineIsLow = !plus && !minus;
    endfunction : lineIsLow

    // Counter load for a span of cycles; zero is the span's last cycle
    function automatic logic [udrh_pkg::COUNT_W-1:0] reloadFor(
        input int unsigned cycles
    );
        reloadFor = udrh_pkg::COUNT_W'(cycles - 1);
    endfunction : reloadFor

    // Down-count by one; callers never step past zero
    function automatic logic [udrh_pkg::COUNT_W-1:0] countDown(
        input logic [udrh_pkg::COUNT_W-1:0] value
    );
        countDown = value - udrh_pkg::COUNT_W'(1);
    endfunction : countDown

    // Soft reset holds while running or on the accepted start edge
    function automatic logic softHeld(
        input logic running,
        input logic starting
    );
        softHeld = running || starting;
    endfunction : softHeld

    udrh_pkg::udrh_state_t        state;
    udrh_pkg::udrh_state_t        next_state;
    logic [udrh_pkg::COUNT_W-1:0] count;
    logic [udrh_pkg::COUNT_W-1:0] next_count;
    logic                         softBusy;

    // Line decode
    wire logic                    seZero;
    wire logic                    linkEnabled;
    wire logic                    resetLine;

    // Phase decode
    wire logic                    countDone;
    wire logic                    inIdle;
    wire logic                    inQualify;
    wire logic                    inActive;
    wire logic                    qualifyDone;
    wire logic                    repeatTick;

    // Soft reset decode
    wire logic                    softStartAccepted;

    // Next values of the output flops
    wire logic                    next_resetIrq;
    wire logic                    next_busResetStatus;
    wire logic                    next_softResetRequestBit;
    wire logic                    next_coreReset_n;

    // Detection is ignored outside device mode or before attach
    assign seZero      = lineIsLow(linePlus, lineMinus);
    assign linkEnabled = deviceMode && attached;
    assign resetLine   = linkEnabled && seZero;

    assign countDone   = (count == '0);
    assign inIdle      = (state == udrh_pkg::UDRH_IDLE);
    assign inQualify   = (state == udrh_pkg::UDRH_QUALIFY);
    assign inActive    = (state == udrh_pkg::UDRH_ACTIVE);
    assign qualifyDone = inQualify && countDone;
    assign repeatTick  = inActive && countDone;

    // Idle keeps the qualify span loaded so a new reset always starts fresh
    assign next_count = inIdle    ? reloadFor(udrh_pkg::RESET_DETECT_CYC) :
                        countDone ? reloadFor(udrh_pkg::RESET_REPEAT_CYC) :
                                    countDown(count);

    // Needs the line still low this cycle: never before or after the reset
    assign next_resetIrq       = resetLine && (qualifyDone || repeatTick);
    // Live level: drops on the first edge with the line released
    assign next_busResetStatus = resetLine && (inActive || qualifyDone);

    // A write while busy is ignored; the running span is not restarted
    assign softStartAccepted        = softResetWrite && !softBusy;
    assign next_softResetRequestBit = softHeld(softBusy, softStartAccepted);
    assign next_coreReset_n         = !softHeld(softBusy, softStartAccepted);

    // Sequencer owns the span length; this module only forms the outputs
    udrh_soft_reset softReset (
        .clock   (clock),
        .reset_n (reset_n),
        .request (softResetWrite),
        .busy    (softBusy)
    );

    // Qualify restarts on any release; a glitch never reaches the
    // interrupt because the whole span must pass with the line low
    always_comb begin
        next_state = state;
        case (state)
            udrh_pkg::UDRH_IDLE: begin
                if (resetLine) begin
                    next_state = udrh_pkg::UDRH_QUALIFY;
                end
            end
            udrh_pkg::UDRH_QUALIFY: begin
                if (!resetLine) begin
                    // Too short to count as a bus reset
                    next_state = udrh_pkg::UDRH_IDLE;
                end else if (countDone) begin
                    next_state = udrh_pkg::UDRH_ACTIVE;
                end
            end
            udrh_pkg::UDRH_ACTIVE: begin
                if (!resetLine) begin
                    next_state = udrh_pkg::UDRH_IDLE;
                end
            end
            default: begin
                next_state = udrh_pkg::UDRH_IDLE;
            end
        endcase
    end

    // Phase register
    // Reset lands in idle so no stale qualify count survives
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= udrh_pkg::UDRH_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Shared counter: qualify span first, then repeat interval
    // Reloaded in idle, so it never wraps through zero there
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // Interrupt is a one-cycle pulse straight from a flop
    // Software may see several of them per bus reset
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            resetIrq <= 1'b0;
        end else begin
            resetIrq <= next_resetIrq;
        end
    end

    // Status bit follows the live line level once the qualify span has passed
    // Its fall marks the end of the bus reset
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busResetStatus <= 1'b0;
        end else begin
            busResetStatus <= next_busResetStatus;
        end
    end

    // Readback of the soft reset bit
    // Stays high one cycle past the sequencer span
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            softResetRequestBit <= 1'b0;
        end else begin
            softResetRequestBit <= next_softResetRequestBit;
        end
    end

    // Internal reset, active low
    // Power-on and system resets come straight from reset_n,
    // which needs no extra sequencing
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            coreReset_n <= 1'b0;
        end else begin
            coreReset_n <= next_coreReset_n;
        end
    end

endmodule : udrh_top

// [verif/udrh_assertions.sv]
// Checker: bus reset interrupt, status and soft reset at the ports.
// Assumes binding into udrh_top, one clock domain.
`timescale 1ns/1ns
module udrh_checker (
    input wire logic clock, reset_n, deviceMode, attached, linePlus, lineMinus,
    input wire logic softResetWrite, resetIrq, busResetStatus, softResetRequestBit, coreReset_n
);
    wire resetLine = deviceMode && attached && !linePlus && !lineMinus;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence softStart; softResetWrite && !softResetRequestBit; endsequence
    AST_IRQ_IN_RESET: assert property (resetIrq |-> busResetStatus && $past(resetLine))
        else $error("irq outside bus reset");
    AST_IRQ_PULSE: assert property (resetIrq |=> !resetIrq) else $error("irq too long");
    AST_STATUS_RISE: assert property ($rose(busResetStatus) |-> resetIrq)
        else $error("status without irq");
    AST_STATUS_CLEAR: assert property (busResetStatus && !resetLine |=> !busResetStatus)
        else $error("status not cleared");
    AST_SOFT_RUN: assert property (softStart |=> (softResetRequestBit && !coreReset_n)[*8]
        ##[8:25] (!softResetRequestBit && coreReset_n)) else $error("soft reset wrong");
    AST_CORE_OUT: assert property (!softResetRequestBit && !softResetWrite && $past(reset_n)
        |=> coreReset_n) else $error("core held in reset");
endmodule : udrh_checker
bind udrh_top udrh_checker i_udrh_checker (.*);

// [verif/udrh_host_model.sv]
// Host model: idles in J, drives both lines low for a bus reset.
// Assumes busReset changes at the falling edge.
`timescale 1ns/1ns
module udrh_host_model (
    input  wire logic clock,
    input  wire logic busReset,
    output logic      linePlus = 1'b1,
    output logic      lineMinus
);
    // Idle J: D+ high, D- low; bus reset pulls D+ low too
    always @(posedge clock) linePlus <= !busReset;
    assign lineMinus = 1'b0;
endmodule : udrh_host_model

// [verif/udrh_top_bench.sv]
// Bench: bus reset and soft reset scenarios for udrh_top.
// Assumes host model and checker compiled first.
`timescale 1ns/1ns
module udrh_top_bench;
    logic clock = 0, reset_n = 0, deviceMode = 1, attached = 1, busReset = 0, softResetWrite = 0;
    logic linePlus, lineMinus, resetIrq, busResetStatus, softResetRequestBit, coreReset_n;
    int error_cnt = 0, compares = 0, irqCnt = 0, n;
    always #10 clock = !clock;
    always @(posedge clock) irqCnt <= irqCnt + (resetIrq === 1'b1);
    udrh_host_model i_udrh_host_model (
        .clock     (clock),
        .busReset  (busReset),
        .linePlus  (linePlus),
        .lineMinus (lineMinus)
    );
    udrh_top i_udrh_top (
        .clock               (clock),
        .reset_n             (reset_n),
        .deviceMode          (deviceMode),
        .attached            (attached),
        .linePlus            (linePlus),
        .lineMinus           (lineMinus),
        .softResetWrite      (softResetWrite),
        .resetIrq            (resetIrq),
        .busResetStatus      (busResetStatus),
        .softResetRequestBit (softResetRequestBit),
        .coreReset_n         (coreReset_n)
    );
    task chk(input logic c, input string m);
        compares++;
        if (c !== 1'b1) begin
            error_cnt++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask : chk
    task cyc(input int k);
        repeat (k) @(negedge clock);
    endtask : cyc
    task bus_reset(input int len, input logic mode, input logic many);
        n = irqCnt;
        deviceMode = mode;
        busReset = 1;
        cyc(len);
        chk(busResetStatus === many && (many ? irqCnt - n >= 2 : irqCnt == n), "irq");
        busReset = 0;
        n = irqCnt;
        cyc(3);
        chk(busResetStatus === 1'b0, "status stuck");
        cyc(100);
        chk(irqCnt == n, "late irq");
        deviceMode = 1;
        $display("Bus reset test done, len %0d", len);
    endtask : bus_reset
    task soft_reset;
        softResetWrite = 1;
        cyc(1);
        chk(softResetRequestBit === 1'b1 && coreReset_n === 1'b0, "soft start");
        cyc(1);
        softResetWrite = 0;
        n = 2;
        while (softResetRequestBit !== 1'b0 && n < 40) begin
            n++;
            cyc(1);
        end
        chk(coreReset_n === 1'b1 && n == udrh_pkg::SOFT_RESET_CYC + 2, "soft length");
        $display("Soft reset test done");
    endtask : soft_reset
    task complete_run;
        $display("Compares %0d, errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        cyc(6);
        reset_n = 1;
        cyc(2);
        chk(coreReset_n === 1'b1 && busResetStatus === 1'b0, "after reset");
        bus_reset(100, 1, 0);
        bus_reset(400, 1, 1);
        bus_reset(400, 0, 0);
        attached = 0;
        bus_reset(400, 1, 0);
        attached = 1;
        soft_reset;
        complete_run;
    end
    initial begin
        #60000;
        error_cnt++;
        complete_run;
    end
endmodule : udrh_top_bench
